//--- slc_defines.vh
// Purpose: Constants for the stack limit checker
// Assumes: 16-bit byte-addressed data space
// Notes:   Included by both design files
`ifndef SLC_DEFINES_VH
`define SLC_DEFINES_VH

`define SLC_WORD_STEP     16'h0002
`define SLC_SFR_TOP       16'h0800
`define SLC_SP_RESET      16'h0800
`define SLC_ALIGN_BIT     0

`define SLC_OP_NONE       3'h0
`define SLC_OP_PUSH       3'h1
`define SLC_OP_POP        3'h2
`define SLC_OP_CALL       3'h3
`define SLC_OP_EXC        3'h4
`define SLC_OP_WRSP       3'h5
`define SLC_OP_WRLIM      3'h6
`define SLC_OP_INDRD      3'h7

`endif

//--- slc_limit_cmp.v
// Purpose: Compare a stack effective address with the limit and floor
// Assumes: Addresses are word aligned
// Notes:   Purely combinational
`timescale 1ns/1ps
`include "slc_defines.vh"

module slc_limit_cmp (
  // Address under test
  input  wire [15:0] effectiveAddress,
  input  wire [15:0] stackLimit,
  // Results
  output wire        overLimit,
  output wire        underFloor
);

  // Limit crossed only when address passes beyond the limit
  assign overLimit  = (effectiveAddress > stackLimit);
  assign underFloor = (effectiveAddress < `SLC_SFR_TOP);

endmodule

//--- slc_stack_limit_checker.v
// Purpose: Stack pointer update, PC push framing and stack error trap
// Assumes: One operation per clk; op held for one cycle; busy stalls new ops
// Notes:   Outputs registered; limit register has no reset value
`timescale 1ns/1ps
`include "slc_defines.vh"

// Behaviour
// - Pointer holds first free word, grows upward
// - Pop pre-decrements, push post-increments pointer
// - Call push clears PC most significant byte
// - Exception push joins status byte onto PC
// - Limit register left uninitialised by reset
// - Bit 0 of pointer and limit forced zero
// - Every pointer-based address checked against limit
// - Push at limit ok, next push traps
// - Stack access address below 0800h raises underflow trap
module slc_stack_limit_checker (
  // Clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // Operation request
  input  wire        opValid,
  input  wire [2:0]  opCode,
  input  wire [15:0] opData,
  input  wire [22:0] programCounter,
  input  wire [7:0]  status_low_byte,
  // Memory write/read port
  output reg         memWrite,
  output reg         memRead,
  output reg  [15:0] effective_address,
  output reg  [15:0] memWriteData,
  // Status
  output reg  [15:0] stack_pointer_out,
  output reg         busy,
  output reg         stackErrorTrap
);

  localparam ST_IDLE = 1'b0;
  localparam ST_HIGH = 1'b1;

  reg         state;
  reg  [15:0] stack_pointer_reg;
  reg  [15:0] stack_limit_reg;
  reg  [15:0] pendingHigh;
  reg  [15:0] next_sp;
  reg  [15:0] next_ea;
  reg         next_access;
  reg         next_isPush;

  wire        overLimit;
  wire        underFloor;

  wire        opTaken;
  wire        isPush;
  wire        isCall;
  wire        isExc;
  wire        isWrSp;
  wire        isWrLim;
  wire [15:0] alignedData;
  wire [15:0] alignedNext;

  // A request counts only while no second PC word is pending
  assign opTaken     = opValid && (state == ST_IDLE);
  assign isPush      = opTaken && (opCode == `SLC_OP_PUSH);
  assign isCall      = opTaken && (opCode == `SLC_OP_CALL);
  assign isExc       = opTaken && (opCode == `SLC_OP_EXC);
  assign isWrSp      = opTaken && (opCode == `SLC_OP_WRSP);
  assign isWrLim     = opTaken && (opCode == `SLC_OP_WRLIM);
  // Stack words are always word aligned
  assign alignedData = {opData[15:1], 1'b0};
  assign alignedNext = {next_sp[15:1], 1'b0};

  // Pushes write at the pointer; pops read one word below it
  always @* begin
    next_sp     = stack_pointer_reg;
    next_ea     = stack_pointer_reg;
    next_access = 1'b0;
    next_isPush = 1'b0;
    if (state == ST_HIGH) begin
      next_access = 1'b1;
      next_isPush = 1'b1;
      next_sp     = stack_pointer_reg + `SLC_WORD_STEP;
    end else if (opValid) begin
      case (opCode)
        `SLC_OP_PUSH, `SLC_OP_CALL, `SLC_OP_EXC: begin
          next_access = 1'b1;
          next_isPush = 1'b1;
          next_sp     = stack_pointer_reg + `SLC_WORD_STEP;
        end
        `SLC_OP_POP: begin
          next_access = 1'b1;
          next_sp     = stack_pointer_reg - `SLC_WORD_STEP;
          next_ea     = next_sp;
        end
        `SLC_OP_INDRD: begin
          next_access = 1'b1;
        end
        default: begin
          next_access = 1'b0;
        end
      endcase
    end
  end

  slc_limit_cmp uCmp (
    .effectiveAddress (next_ea),
    .stackLimit       (stack_limit_reg),
    .overLimit        (overLimit),
    .underFloor       (underFloor)
  );

  // Limit register: no reset term at all
  always @(posedge clk) begin
    if (isWrLim) begin
      stack_limit_reg <= alignedData;
    end
  end

  // Memory strobes pulse for one cycle per stack word
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memWrite <= 1'b0;
      memRead  <= 1'b0;
    end else begin
      memWrite <= next_access & next_isPush;
      memRead  <= next_access & ~next_isPush;
    end
  end

  // Trap rides with the access that caused it
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stackErrorTrap <= 1'b0;
    end else begin
      stackErrorTrap <= next_access & (overLimit | underFloor);
    end
  end

  // Address holds between accesses
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      effective_address <= 16'h0000;
    end else if (next_access) begin
      effective_address <= next_ea;
    end
  end

  // Working pointer; a pointer write replaces the computed step
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_pointer_reg <= `SLC_SP_RESET;
    end else if (isWrSp) begin
      stack_pointer_reg <= alignedData;
    end else begin
      stack_pointer_reg <= alignedNext;
    end
  end

  // Visible copy of the pointer, same update as the working one
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stack_pointer_out <= `SLC_SP_RESET;
    end else if (isWrSp) begin
      stack_pointer_out <= alignedData;
    end else begin
      stack_pointer_out <= alignedNext;
    end
  end

  // High PC word is captured with the request and sent one cycle later
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendingHigh <= 16'h0000;
    end else if (isCall) begin
      pendingHigh <= {8'h00, 1'b0, programCounter[22:16]};
    end else if (isExc) begin
      pendingHigh <= {status_low_byte, 1'b0, programCounter[22:16]};
    end
  end

  // Write data: low PC word first, pending high word next
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memWriteData <= 16'h0000;
    end else if (state == ST_HIGH) begin
      memWriteData <= pendingHigh;
    end else if (isPush) begin
      memWriteData <= opData;
    end else if (isCall || isExc) begin
      memWriteData <= programCounter[15:0];
    end
  end

  // Second PC word sequencer; busy marks the cycle in which requests are refused
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (isCall || isExc) begin
            state <= ST_HIGH;
            busy  <= 1'b1;
          end else begin
            state <= ST_IDLE;
            busy  <= 1'b0;
          end
        end
        ST_HIGH: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
        default: begin
          state <= ST_IDLE;
          busy  <= 1'b0;
        end
      endcase
    end
  end

endmodule

//--- slc_mem.sv
// Purpose: Stack memory model on the far side
// Assumes: Word aligned accesses
// Notes: Returns the last word read, by pop or indirect read
`timescale 1ns/1ps
module slc_mem (
  input wire clk, memWrite, memRead,
  input wire [15:0] effective_address, memWriteData,
  output reg [15:0] lastPopped
);
  reg [15:0] m [0:32767];
  always @(posedge clk) begin
    if (memWrite) m[effective_address[15:1]] <= memWriteData;
    if (memRead) lastPopped <= m[effective_address[15:1]];
  end
endmodule

//--- slc_chk.sv
// Purpose: Stack checker assertions
// Assumes: Limit written before stack use
// Notes: Limit mirrored in helper logic
`timescale 1ns/1ps
module slc_chk (
  input wire clk, sys_rst, opValid, busy, memWrite, memRead, stackErrorTrap,
  input wire [2:0] opCode,
  input wire [15:0] opData, effective_address, memWriteData, stack_pointer_out,
  input wire [22:0] programCounter,
  input wire [7:0] status_low_byte
);
  reg [15:0] lim;
  wire g = opValid & ~busy;
  wire [15:0] ea = effective_address;
  wire [15:0] sp = stack_pointer_out;
  wire [15:0] wd = memWriteData;
  always @(posedge clk) if (g && opCode == 3'h6) lim <= {opData[15:1], 1'b0};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  push_step_a: assert property (
    g && opCode == 3'h1 |=> memWrite && ea == $past(sp) && sp == ea + 16'h2) else $error("push");
  pop_step_a: assert property (
    g && opCode == 3'h2 |=> memRead && ea == $past(sp) - 16'h2 && sp == ea) else $error("pop");
  pc_pair_a: assert property (
    g && (opCode == 3'h3 || opCode == 3'h4) |=> memWrite && busy && wd == $past(programCounter[15:0])
    ##1 memWrite && ea == $past(ea) + 16'h2 && wd[6:0] == $past(programCounter[22:16], 2)) else $error("pc");
  call_msb_a: assert property (
    g && opCode == 3'h3 |=> ##1 wd[15:7] == 9'h0) else $error("call");
  exc_status_a: assert property (
    g && opCode == 3'h4 |=> ##1 wd[15:8] == $past(status_low_byte, 2)) else $error("exc");
  sp_align_a: assert property (sp[0] == 1'b0) else $error("align");
  limit_trap_a: assert property (
    memWrite || memRead |-> stackErrorTrap == (ea > lim || ea < 16'h0800)) else $error("trap");
  trap_access_a: assert property (stackErrorTrap |-> memWrite || memRead) else $error("stray");
  indirect_read_a: assert property (
    g && opCode == 3'h7 |=> memRead && !memWrite && ea == $past(sp) && sp == $past(sp)) else $error("indirect");
  cover property (g && opCode == 3'h7);
  cover property (g && opCode == 3'h3);
  cover property (g && opCode == 3'h4);
  cover property (stackErrorTrap);
endmodule
bind slc_stack_limit_checker slc_chk u_chk (
  .clk(clk), .sys_rst(sys_rst), .opValid(opValid), .busy(busy), .memWrite(memWrite), .memRead(memRead),
  .stackErrorTrap(stackErrorTrap), .opCode(opCode), .opData(opData), .effective_address(effective_address),
  .memWriteData(memWriteData), .stack_pointer_out(stack_pointer_out), .programCounter(programCounter),
  .status_low_byte(status_low_byte));

//--- test_stack_limit_checker.sv
// Purpose: Bench for the stack checker
// Assumes: 10 MHz clock
// Notes: Seeded random data
`timescale 1ns/1ps
module test_stack_limit_checker;
  reg clk = 0, sys_rst = 1, opValid = 0, sawTrap = 0;
  reg [2:0] opCode = 0;
  reg [7:0] status_low_byte = 0;
  reg [15:0] opData = 0, d;
  reg [22:0] programCounter = 0;
  reg [31:0] rnd;
  wire memWrite, memRead, busy, stackErrorTrap;
  wire [15:0] effective_address, memWriteData, stack_pointer_out, lastPopped;
  integer num_errors = 0, n_checks = 0, seed = 88674, cyc = 0, i;
  slc_stack_limit_checker DUT (
    .clk(clk), .sys_rst(sys_rst), .opValid(opValid), .opCode(opCode), .opData(opData),
    .programCounter(programCounter), .status_low_byte(status_low_byte), .memWrite(memWrite),
    .memRead(memRead), .effective_address(effective_address), .memWriteData(memWriteData),
    .stack_pointer_out(stack_pointer_out), .busy(busy), .stackErrorTrap(stackErrorTrap));
  slc_mem u_mem (
    .clk(clk), .memWrite(memWrite), .memRead(memRead), .effective_address(effective_address),
    .memWriteData(memWriteData), .lastPopped(lastPopped));
  function [15:0] high_word(input isExc, input [7:0] sb, input [22:0] pc);
    begin
      high_word = {isExc ? sb : 8'h00, 1'b0, pc[22:16]};
    end
  endfunction
  initial forever #50 clk = ~clk;
  task end_sim;
    begin
      if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (opValid) sawTrap <= 1'b0;
    else if (stackErrorTrap) sawTrap <= 1'b1;
    if (cyc == 2000) begin
      num_errors = num_errors + 1;
      end_sim;
    end
  end
  task chk(input ok);
    begin
      n_checks = n_checks + 1;
      if (!ok) begin
        num_errors = num_errors + 1;
        $display("FAIL %0t mismatch", $time);
      end
    end
  endtask
  task op(input [2:0] c, input [15:0] v);
    begin
      @(posedge clk);
      opValid <= 1'b1;
      opCode <= c;
      opData <= v;
      @(posedge clk);
      opValid <= 1'b0;
      @(posedge clk);
      #1;
    end
  endtask
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    op(3'h6, 16'h0805);
    for (i = 0; i < 4; i = i + 1) begin
      rnd = $random(seed);
      op(3'h1, rnd[15:0]);
      chk(sawTrap === (i == 3));
    end
    chk(stack_pointer_out === 16'h0808);
    op(3'h6, 16'hfffe);
    for (i = 0; i < 20; i = i + 1) begin
      rnd = $random(seed);
      d = rnd[15:0];
      op(3'h1, d);
      op(3'h2, 16'h0000);
      chk(lastPopped === d && stack_pointer_out === 16'h0808);
    end
    for (i = 3; i < 5; i = i + 1) begin
      rnd = $random(seed);
      @(posedge clk);
      programCounter <= rnd[22:0];
      status_low_byte <= rnd[30:23];
      op(i[2:0], 16'h0000);
      op(3'h2, 16'h0000);
      chk(lastPopped === high_word(i == 4, status_low_byte, programCounter));
      op(3'h2, 16'h0000);
      chk(lastPopped === programCounter[15:0]);
    end
    op(3'h5, 16'h0800);
    op(3'h2, 16'h0000);
    chk(sawTrap === 1'b1);
    op(3'h6, 16'h0801);
    op(3'h5, 16'h0903);
    chk(stack_pointer_out === 16'h0902);
    op(3'h7, 16'h0000);
    chk(sawTrap === 1'b1 && stack_pointer_out === 16'h0902);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    #1;
    chk(stack_pointer_out === 16'h0800 && busy === 1'b0);
    op(3'h1, 16'h1234);
    chk(sawTrap === 1'b0);
    op(3'h1, 16'h5678);
    chk(sawTrap === 1'b1);
    end_sim;
  end
endmodule
